// *** logic/lgdr_relays.sv ***
// Operation
// - or output high when any input high
// - inverter output is input complemented
// - nand low only when all inputs high
// - nor high only when all inputs low
// - xor high when two inputs differ
// - on-delay rising trigger starts timer
// - on-delay output high after full delay
// - on-delay trigger low clears output, timing
// - on-delay time 0.01-99.99 s/min/h
// - off-delay output high while trigger high
// - off-delay falling trigger starts timer, output held
// - off-delay expiry clears output and timer
// - each falling trigger restarts off-delay timer
// - off-delay clear resets timer, output, overrides trigger
// - off-delay time same range and units
// - toggle relay inverts on rising trigger
// - toggle clear forces zero, beats trigger
`timescale 1ns/1ps
`include "lgdr_regs.svh"
module lgdr_relays #(
   parameter int TICK_CYCLES = `LGDR_TICK_CYCLES, // cycles per 0.01 s
   parameter int CNT_W = 26 // timer width, fits 99.99 h in ticks
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic sync_clear_i, // synchronous clear of the on-delay, off-delay and toggle relays
   input wire lgdr_pkg::lgdr_gate_in_t gate_in_i, // field inputs of 3-input gates
   input wire logic not_input_i,
   input wire logic xor_input_a_i,
   input wire logic xor_input_b_i,
   input wire logic on_delay_trigger_input_i,
   input wire lgdr_pkg::lgdr_time_t on_delay_time_i,
   input wire logic off_delay_trigger_input_i,
   input wire logic off_delay_clear_i,
   input wire lgdr_pkg::lgdr_time_t off_delay_time_i,
   input wire logic toggle_trigger_input_i,
   input wire logic toggle_clear_i,
   output logic or_o,
   output logic not_o,
   output logic nand_o,
   output logic nor_o,
   output logic xor_o,
   output logic on_delay_relay_o,
   output logic off_delay_relay_o,
   output logic toggle_relay_o
);
   localparam int NSYNC = 11; // number of synchronised inputs
   localparam int IX_ON = 4; // slot of the on-delay trigger
   localparam int IX_OFT = 3; // slot of the off-delay trigger
   localparam int IX_TGT = 1; // slot of the toggle trigger

   // field pins gathered for synchronisation
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync_a; // first stage, read only by sync_b
   logic [NSYNC-1:0] sync_b; // second stage, safe to use
   logic [NSYNC-1:0] prev_b; // previous-cycle copy for edges

   // every field pin, toggle clear in the lowest slot
   assign raw_in = {gate_in_i.gate_input_a, gate_in_i.gate_input_b, gate_in_i.gate_input_c,
                    not_input_i, xor_input_a_i, xor_input_b_i, on_delay_trigger_input_i,
                    off_delay_trigger_input_i, off_delay_clear_i, toggle_trigger_input_i,
                    toggle_clear_i};

   // two-flop synchroniser plus edge history, one per input
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
               prev_b[gi] <= 1'b0;
            end else begin
               sync_a[gi] <= raw_in[gi];
               sync_b[gi] <= sync_a[gi];
               prev_b[gi] <= sync_b[gi];
            end
         end
      end
   endgenerate

   // named views of synchronised inputs
   logic in_a; // gate input a
   logic in_b; // gate input b
   logic in_c; // gate input c
   logic in_not; // inverter input
   logic in_xa; // first xor input
   logic in_xb; // second xor input
   logic on_trig; // on-delay trigger level
   logic off_trig; // off-delay trigger level
   logic off_clr; // off-delay clear level
   logic tog_trig; // toggle trigger level
   logic tog_clr; // toggle clear level
   logic on_rise; // on-delay trigger went 0 to 1
   logic off_fall; // off-delay trigger went 1 to 0
   logic tog_rise; // toggle trigger went 0 to 1
   assign {in_a, in_b, in_c, in_not, in_xa, in_xb, on_trig, off_trig, off_clr, tog_trig, tog_clr} = sync_b;
   // edges against the value one cycle back
   assign on_rise = on_trig && !prev_b[IX_ON];
   assign off_fall = !off_trig && prev_b[IX_OFT];
   assign tog_rise = tog_trig && !prev_b[IX_TGT];

   // combinational gates, registered for clean data outputs
   logic next_or; // or gate result
   logic next_not; // inverter result
   logic next_nand; // nand gate result
   logic next_nor; // nor gate result
   logic next_xor; // xor gate result
   always_comb begin
      next_or = in_a | in_b | in_c;
      next_not = ~in_not;
      next_nand = ~(in_a & in_b & in_c);
      next_nor = ~(in_a | in_b | in_c);
      next_xor = in_xa ^ in_xb;
   end

   // register gate outputs
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         or_o <= 1'b0;
         not_o <= 1'b0;
         nand_o <= 1'b0;
         nor_o <= 1'b0;
         xor_o <= 1'b0;
      end else begin
         or_o <= next_or;
         not_o <= next_not;
         nand_o <= next_nand;
         nor_o <= next_nor;
         xor_o <= next_xor;
      end
   end

   // 0.01 s time base divider, one-cycle enable pulse
   logic [23:0] div_cnt; // cycles into the current tick
   logic [23:0] next_div_cnt;
   logic tick; // one-cycle pulse per 0.01 s
   // compute tick and the next divider count
   always_comb begin
      tick = (div_cnt == 24'(TICK_CYCLES - 1));
      next_div_cnt = tick ? 24'h00_0000 : div_cnt + 24'h00_0001;
   end
   // register the divider
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt <= 24'h00_0000;
      end else begin
         div_cnt <= next_div_cnt;
      end
   end

   // on-delay relay control
   lgdr_pkg::lgdr_state_t on_state; // where the on-delay relay stands
   lgdr_pkg::lgdr_state_t next_on_state;
   logic on_q; // on-delay output flop
   logic next_on_q;
   logic on_start; // load the on-delay timer
   logic on_abort; // drop any on-delay timing
   logic on_exp; // on-delay time has run out
   // next on-delay state and output
   always_comb begin
      next_on_state = on_state;
      on_start = 1'b0;
      on_abort = 1'b0;
      if (sync_clear_i) begin
         // global clear wins over everything
         next_on_state = lgdr_pkg::LGDR_IDLE;
         on_abort = 1'b1;
      end else if (!on_trig) begin
         // trigger low: output off, timing abandoned
         next_on_state = lgdr_pkg::LGDR_IDLE;
         on_abort = 1'b1;
      end else begin
         unique case (on_state)
            lgdr_pkg::LGDR_IDLE: begin
               // wait for a fresh rising trigger
               if (on_rise) begin
                  next_on_state = lgdr_pkg::LGDR_TIMING;
                  on_start = 1'b1;
               end
            end
            lgdr_pkg::LGDR_TIMING: begin
               // trigger held high until the time runs out
               if (on_exp) begin
                  next_on_state = lgdr_pkg::LGDR_DONE;
               end
            end
            lgdr_pkg::LGDR_DONE: begin
               // output stays on while the trigger stays high
               next_on_state = lgdr_pkg::LGDR_DONE;
            end
         endcase
      end
      // output flop follows the state being entered
      next_on_q = (next_on_state == lgdr_pkg::LGDR_DONE);
   end

   // on-delay state and output registers
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         on_state <= lgdr_pkg::LGDR_IDLE;
         on_q <= 1'b0;
      end else begin
         on_state <= next_on_state;
         on_q <= next_on_q;
      end
   end
   assign on_delay_relay_o = on_q;

   // on-delay timer, value and unit programmable
   lgdr_delay_timer #(
      .CNT_W(CNT_W)
   ) u_on_timer (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .tick_i(tick),
      .start_i(on_start),
      .abort_i(on_abort),
      .time_i(on_delay_time_i),
      .running_o(),
      .expired_o(on_exp)
   );

   // off-delay relay control
   logic off_q;
   logic next_off_q;
   logic off_start; // load the off-delay timer
   logic off_abort; // drop any off-delay timing
   logic off_exp; // off-delay time has run out
   // next off-delay output and timer controls
   always_comb begin
      next_off_q = off_q;
      off_start = 1'b0;
      off_abort = 1'b0;
      if (sync_clear_i || off_clr) begin
         // clear wins over the trigger
         next_off_q = 1'b0;
         off_abort = 1'b1;
      end else if (off_trig) begin
         // trigger high: output on, timer held off
         next_off_q = 1'b1;
         off_abort = 1'b1;
      end else if (off_fall) begin
         // falling trigger starts the delay afresh
         next_off_q = 1'b1;
         off_start = 1'b1;
      end else if (off_exp) begin
         // delay over: output drops
         next_off_q = 1'b0;
      end
   end

   // off-delay output register
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         off_q <= 1'b0;
      end else begin
         off_q <= next_off_q;
      end
   end
   assign off_delay_relay_o = off_q;

   // off-delay timer
   lgdr_delay_timer #(
      .CNT_W(CNT_W)
   ) u_off_timer (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .tick_i(tick),
      .start_i(off_start),
      .abort_i(off_abort),
      .time_i(off_delay_time_i),
      .running_o(),
      .expired_o(off_exp)
   );

   // toggle relay: clear wins over trigger
   logic tog_q;
   logic next_tog_q;
   // next toggle output
   always_comb begin
      next_tog_q = tog_q;
      if (sync_clear_i || tog_clr) begin
         // clear level holds the output low
         next_tog_q = 1'b0;
      end else if (tog_rise) begin
         // each rising trigger flips the output
         next_tog_q = ~tog_q;
      end
   end

   // toggle output register
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tog_q <= 1'b0;
      end else begin
         tog_q <= next_tog_q;
      end
   end
   assign toggle_relay_o = tog_q;
endmodule : lgdr_relays

// *** logic/lgdr_regs.svh ***
`ifndef LGDR_REGS_SVH
`define LGDR_REGS_SVH
// system clock rate in hz
`define LGDR_CLK_HZ 10000000
// time base tick, 0.01 s of the programmed value
`define LGDR_TICK_MS 10
// cycles per 0.01 s tick derived from the clock rate
`define LGDR_TICK_CYCLES ((`LGDR_CLK_HZ / 1000) * `LGDR_TICK_MS)
// unit multipliers: ticks per 0.01 unit
`define LGDR_MULT_SEC 1
`define LGDR_MULT_MIN 60
`define LGDR_MULT_HOUR 3600
// largest programmable value, 99.99 in hundredths
`define LGDR_TIME_MAX 9999
// unit encodings
`define LGDR_UNIT_SEC 2'h0
`define LGDR_UNIT_MIN 2'h1
`define LGDR_UNIT_HOUR 2'h2
`endif

// *** logic/lgdr_pkg.sv ***
package lgdr_pkg;
   // time setting: value in hundredths plus unit code
   typedef struct packed {
      logic [13:0] value;
      logic [1:0] unit;
   } lgdr_time_t;
   // inputs to a three-input gate
   typedef struct packed {
      logic gate_input_a;
      logic gate_input_b;
      logic gate_input_c;
   } lgdr_gate_in_t;
   // timed relay states
   typedef enum logic [1:0] {LGDR_IDLE, LGDR_TIMING, LGDR_DONE} lgdr_state_t;
endpackage : lgdr_pkg

// *** logic/lgdr_delay_timer.sv ***
`timescale 1ns/1ps
`include "lgdr_regs.svh"
// counts programmed time in time-base ticks; restartable
module lgdr_delay_timer #(
   parameter int CNT_W = 26
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic start_i,
   input wire logic abort_i,
   input wire lgdr_pkg::lgdr_time_t time_i,
   output logic running_o,
   output logic expired_o
);
   logic [CNT_W-1:0] count; // ticks remaining
   logic [CNT_W-1:0] next_count;
   logic running;
   logic next_running;
   logic expired;
   logic next_expired;
   logic [CNT_W-1:0] load; // total ticks for this setting
   logic [13:0] val_clip; // value limited to 99.99

   // convert programmed value and unit to ticks
   always_comb begin
      val_clip = (time_i.value > 14'(`LGDR_TIME_MAX)) ? 14'(`LGDR_TIME_MAX) : time_i.value;
      unique case (time_i.unit)
         `LGDR_UNIT_MIN: load = CNT_W'(val_clip) * CNT_W'(`LGDR_MULT_MIN);
         `LGDR_UNIT_HOUR: load = CNT_W'(val_clip) * CNT_W'(`LGDR_MULT_HOUR);
         default: load = CNT_W'(val_clip) * CNT_W'(`LGDR_MULT_SEC);
      endcase
   end

   // next counter state; abort beats start beats counting
   always_comb begin
      next_count = count;
      next_running = running;
      next_expired = 1'b0;
      if (abort_i) begin
         next_running = 1'b0;
         next_count = '0;
      end else if (start_i) begin
         // zero setting expires on the next cycle
         next_running = (load != '0);
         next_count = load;
         next_expired = (load == '0);
      end else if (running && tick_i) begin
         if (count == CNT_W'(1)) begin
            next_running = 1'b0;
            next_expired = 1'b1;
            next_count = '0;
         end else begin
            next_count = count - CNT_W'(1);
         end
      end
   end

   // register timer state
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count <= '0;
         running <= 1'b0;
         expired <= 1'b0;
      end else begin
         count <= next_count;
         running <= next_running;
         expired <= next_expired;
      end
   end

   assign running_o = running;
   assign expired_o = expired;
endmodule : lgdr_delay_timer

// *** tb/lgdr_field_model.sv ***
`timescale 1ns/1ps
// field switches feeding the relay block
module lgdr_field_model (
   input wire logic clock_i,
   input wire logic [10:0] want_i, // levels the bench asks for
   output logic [10:0] pin_o // contact levels seen by the block
);
   // a contact moves just after an edge, never mid-cycle
   always @(posedge clock_i) begin
      pin_o <= want_i;
   end
endmodule : lgdr_field_model

// *** tb/lgdr_relays_monitor.sv ***
`timescale 1ns/1ps
// watches the relay block at its ports
module lgdr_relays_chk (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic sync_clear_i,
   input wire lgdr_pkg::lgdr_gate_in_t gate_in_i,
   input wire logic not_input_i,
   input wire logic xor_input_a_i,
   input wire logic xor_input_b_i,
   input wire logic on_delay_trigger_input_i,
   input wire logic off_delay_trigger_input_i,
   input wire logic off_delay_clear_i,
   input wire logic toggle_trigger_input_i,
   input wire logic toggle_clear_i,
   input wire logic or_o,
   input wire logic not_o,
   input wire logic nand_o,
   input wire logic nor_o,
   input wire logic xor_o,
   input wire logic on_delay_relay_o,
   input wire logic off_delay_relay_o,
   input wire logic toggle_relay_o
);
   // edges since reset release, held at 4 so the sync pipe is full
   logic [2:0] up;
   logic [2:0] next_up;
   // count until bit 2 is set
   always_comb begin
      next_up = up[2] ? up : up + 3'h1;
   end
   // register the count
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         up <= 3'h0;
      end else begin
         up <= next_up;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   property p_or; up[2] |-> or_o == (|$past(gate_in_i, 3)); endproperty
   a_or: assert property (p_or) else $error("or output wrong");
   property p_not; up[2] |-> not_o == !$past(not_input_i, 3); endproperty
   a_not: assert property (p_not) else $error("not output wrong");
   property p_nand; up[2] |-> nand_o == !(&$past(gate_in_i, 3)); endproperty
   a_nand: assert property (p_nand) else $error("nand output wrong");
   property p_nor; up[2] |-> nor_o == !(|$past(gate_in_i, 3)); endproperty
   a_nor: assert property (p_nor) else $error("nor output wrong");
   property p_xor; up[2] |-> xor_o == ($past(xor_input_a_i, 3) ^ $past(xor_input_b_i, 3)); endproperty
   a_xor: assert property (p_xor) else $error("xor output wrong");
   property p_on_low; up[2] && !$past(on_delay_trigger_input_i, 3) |-> !on_delay_relay_o; endproperty
   a_on_low: assert property (p_on_low) else $error("on-delay high without trigger");
   property p_off_hi; up[2] && $past(off_delay_trigger_input_i, 3) && !$past(off_delay_clear_i, 3)
      && !$past(sync_clear_i) |-> off_delay_relay_o; endproperty
   a_off_hi: assert property (p_off_hi) else $error("off-delay low with trigger");
   property p_off_clr; up[2] && $past(off_delay_clear_i, 3) |-> !off_delay_relay_o; endproperty
   a_off_clr: assert property (p_off_clr) else $error("off-delay not cleared");
   property p_tog; up[2] && $past(toggle_trigger_input_i, 3) && !$past(toggle_trigger_input_i, 4)
      && !$past(toggle_clear_i, 3) && !$past(sync_clear_i) |-> toggle_relay_o != $past(toggle_relay_o); endproperty
   a_tog: assert property (p_tog) else $error("toggle did not flip");
   property p_tog_clr; up[2] && $past(toggle_clear_i, 3) |-> !toggle_relay_o; endproperty
   a_tog_clr: assert property (p_tog_clr) else $error("toggle not cleared");
   property p_sync; $past(sync_clear_i) |-> !toggle_relay_o && !on_delay_relay_o; endproperty
   a_sync: assert property (p_sync) else $error("sync clear missed");
endmodule : lgdr_relays_chk
bind lgdr_relays lgdr_relays_chk chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .sync_clear_i(sync_clear_i),
   .gate_in_i(gate_in_i), .not_input_i(not_input_i), .xor_input_a_i(xor_input_a_i),
   .xor_input_b_i(xor_input_b_i), .on_delay_trigger_input_i(on_delay_trigger_input_i),
   .off_delay_trigger_input_i(off_delay_trigger_input_i), .off_delay_clear_i(off_delay_clear_i),
   .toggle_trigger_input_i(toggle_trigger_input_i), .toggle_clear_i(toggle_clear_i), .or_o(or_o),
   .not_o(not_o), .nand_o(nand_o), .nor_o(nor_o), .xor_o(xor_o), .on_delay_relay_o(on_delay_relay_o),
   .off_delay_relay_o(off_delay_relay_o), .toggle_relay_o(toggle_relay_o));

// *** tb/testbench.sv ***
`timescale 1ns/1ps
// self-checking bench for the gates and timed relays
module testbench;
   localparam int TK = 10; // cycles per tick, shortened for sim
   localparam int ON = 4; // switch positions in the pin vector
   localparam int OFT = 3;
   localparam int OFC = 2;
   localparam int TGT = 1;
   localparam int TGC = 0;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic sync_clear_i = 1'b0;
   logic [10:0] want = 11'h000; // asked switch levels
   logic [10:0] pin; // switch levels at the block
   lgdr_pkg::lgdr_time_t on_delay_time_i = {14'h0005, 2'h0};
   lgdr_pkg::lgdr_time_t off_delay_time_i = {14'h0005, 2'h0};
   logic or_o, not_o, nand_o, nor_o, xor_o;
   logic on_delay_relay_o, off_delay_relay_o, toggle_relay_o;
   int err_count = 0;
   int checks = 0;
   int cnt = 0; // cycle count for the hang limit
   // rows: gate inputs abc, then or not nand nor xor (not gets a, xor gets b c)
   logic [7:0] rows [8] = '{8'h0e, 8'h3d, 8'h5d, 8'h7c, 8'h94, 8'hb5, 8'hd5, 8'hf0};
   int tc [3] = '{TK * 5, TK * 60, TK * 3600}; // delay in cycles per unit row
   logic [13:0] tv [3] = '{14'h0005, 14'h0001, 14'h0001};
   always #50 clock_i = ~clock_i;
   lgdr_field_model sw (.clock_i(clock_i), .want_i(want), .pin_o(pin));
   lgdr_relays #(.TICK_CYCLES(TK)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .sync_clear_i(sync_clear_i),
      .gate_in_i(lgdr_pkg::lgdr_gate_in_t'(pin[10:8])), .not_input_i(pin[7]),
      .xor_input_a_i(pin[6]), .xor_input_b_i(pin[5]), .on_delay_trigger_input_i(pin[ON]),
      .on_delay_time_i(on_delay_time_i), .off_delay_trigger_input_i(pin[OFT]),
      .off_delay_clear_i(pin[OFC]), .off_delay_time_i(off_delay_time_i),
      .toggle_trigger_input_i(pin[TGT]), .toggle_clear_i(pin[TGC]), .or_o(or_o), .not_o(not_o),
      .nand_o(nand_o), .nor_o(nor_o), .xor_o(xor_o), .on_delay_relay_o(on_delay_relay_o),
      .off_delay_relay_o(off_delay_relay_o), .toggle_relay_o(toggle_relay_o));
   // compare and count
   task chk(input logic [4:0] got, input logic [4:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // wait n edges, then step past the edge
   task cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : cyc
   // move one switch at the next edge
   task pin_to(input int b, input logic v);
      @(posedge clock_i);
      want[b] <= v;
   endtask : pin_to
   // short press of one switch
   task pulse(input int b);
      pin_to(b, 1'b1);
      cyc(3);
      pin_to(b, 1'b0);
      cyc(6);
   endtask : pulse
   task stop_test;
      $display("mismatches %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test
   // hang limit well past the longest delay
   always @(posedge clock_i) begin
      cnt <= cnt + 1;
      if (cnt == 60000) begin
         err_count++;
         stop_test();
      end
   end
   initial begin
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      cyc(2);
      foreach (rows[i]) begin
         @(posedge clock_i);
         want[10:5] <= {rows[i][7:5], rows[i][7:5]};
         cyc(6);
         chk({or_o, not_o, nand_o, nor_o, xor_o}, rows[i][4:0]);
      end
      // on-delay in each unit
      for (int u = 0; u < 3; u++) begin
         @(posedge clock_i);
         on_delay_time_i <= {tv[u], 2'(u)};
         pin_to(ON, 1'b1);
         cyc(tc[u] - 12);
         chk(5'(on_delay_relay_o), 5'h00);
         cyc(37);
         chk(5'(on_delay_relay_o), 5'h01);
         pin_to(ON, 1'b0);
         cyc(6);
         chk(5'(on_delay_relay_o), 5'h00);
      end
      // trigger dips mid-count: timing starts over
      @(posedge clock_i);
      on_delay_time_i <= {14'h0005, 2'h0};
      pin_to(ON, 1'b1);
      cyc(30);
      pin_to(ON, 1'b0);
      cyc(2);
      pin_to(ON, 1'b1);
      cyc(38);
      chk(5'(on_delay_relay_o), 5'h00);
      cyc(25);
      chk(5'(on_delay_relay_o), 5'h01);
      pin_to(ON, 1'b0);
      // off-delay: hold, expire, restart on a second fall
      pin_to(OFT, 1'b1);
      cyc(5);
      chk(5'(off_delay_relay_o), 5'h01);
      pin_to(OFT, 1'b0);
      cyc(38);
      chk(5'(off_delay_relay_o), 5'h01);
      cyc(25);
      chk(5'(off_delay_relay_o), 5'h00);
      pulse(OFT);
      cyc(24);
      pulse(OFT);
      cyc(32);
      chk(5'(off_delay_relay_o), 5'h01);
      cyc(25);
      chk(5'(off_delay_relay_o), 5'h00);
      // clear mid-count, then against a high trigger
      pulse(OFT);
      pin_to(OFC, 1'b1);
      cyc(5);
      chk(5'(off_delay_relay_o), 5'h00);
      pin_to(OFT, 1'b1);
      cyc(5);
      chk(5'(off_delay_relay_o), 5'h00);
      pin_to(OFC, 1'b0);
      cyc(5);
      chk(5'(off_delay_relay_o), 5'h01);
      pin_to(OFT, 1'b0);
      // toggle relay flips, clear wins over trigger
      for (int k = 1; k < 4; k++) begin
         pulse(TGT);
         chk(5'(toggle_relay_o), 5'(k % 2));
      end
      pin_to(TGC, 1'b1);
      cyc(5);
      chk(5'(toggle_relay_o), 5'h00);
      pulse(TGT);
      chk(5'(toggle_relay_o), 5'h00);
      pin_to(TGC, 1'b0);
      pulse(TGT);
      // off-delay timed in minutes
      @(posedge clock_i);
      off_delay_time_i <= {14'h0001, 2'h1};
      pulse(OFT);
      cyc(TK * 60 - 22);
      chk(5'(off_delay_relay_o), 5'h01);
      cyc(37);
      chk(5'(off_delay_relay_o), 5'h00);
      // one-cycle global clear with off-delay still timing
      pulse(OFT);
      @(posedge clock_i);
      sync_clear_i <= 1'b1;
      @(posedge clock_i);
      sync_clear_i <= 1'b0;
      cyc(1);
      chk({3'h0, toggle_relay_o, off_delay_relay_o}, 5'h00);
      // reset in mid-run drops the relays
      pulse(TGT);
      pin_to(OFT, 1'b1);
      cyc(5);
      @(posedge clock_i);
      rst_n_i <= 1'b0;
      cyc(1);
      chk({3'h0, toggle_relay_o, off_delay_relay_o}, 5'h00);
      @(posedge clock_i);
      rst_n_i <= 1'b1;
      cyc(5);
      chk({3'h0, toggle_relay_o, off_delay_relay_o}, 5'h01);
      stop_test();
   end
endmodule : testbench
